/* File: inc/batch_defines.vh */
// Constants for the batch sequencer: register map, step entry layout, timing.
// Assumes a 125 MHz system clock and an Avalon-MM word-addressed slave port.
`ifndef BATCH_DEFINES_VH
`define BATCH_DEFINES_VH

// Timing
`define CLK_PERIOD_NS 8
`define TENTH_SEC_NS 100000000
`define TICK_CYCLES (`TENTH_SEC_NS / `CLK_PERIOD_NS)

// Register word indexes
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_STATUS 4'h2
`define REG_IRQ_STAT 4'h3
`define REG_IRQ_MASK 4'h4
`define REG_STEP_SEL 4'h5
`define REG_STEP_LO 4'h6
`define REG_STEP_HI 4'h7
`define REG_WATCH0 8

// Command bits of REG_CMD
`define CMD_START 0
`define CMD_HOLD 1
`define CMD_HALT 2
`define CMD_REWIND 3

// Interrupt bits
`define IRQ_DONE 0
`define IRQ_ALARM 1
`define IRQ_GATE 2
`define IRQ_PAUSE 3

// Step entry fields
`define F_KIND_LO 0
`define F_KIND_HI 2
`define F_TRIP_LO 3
`define F_TRIP_HI 4
`define F_OSEL_LO 5
`define F_OSEL_HI 7
`define F_TARE 8
`define F_VAL_LO 16
`define F_VAL_HI 31
`define F_AUX_LO 32
`define F_AUX_HI 47

// Step kinds
`define KIND_OFF 3'h0
`define KIND_GROSS 3'h1
`define KIND_NET 3'h2
`define KIND_PAUSE 3'h3
`define KIND_DELAY 3'h4
`define KIND_WAIT_SETTLE_KIND 3'h5

// Trip modes
`define TRIP_HIGHER 2'h0
`define TRIP_LOWER 2'h1
`define TRIP_WITHIN_BAND_TRIP 2'h2

// Watch register fields
`define W_START_LO 0
`define W_START_HI 3
`define W_END_LO 4
`define W_END_HI 7
`define W_OSEL_LO 8
`define W_OSEL_HI 10
`define W_CONCUR 11
`define W_EN 12
`define W_VAL_LO 16
`define W_VAL_HI 31

`endif

/* File: src/signal_sync.v */
// Two-stage synchroniser for a group of level inputs.
// Assumes inputs are idle high; reset loads the idle level.
`timescale 1ns/10ps
module signal_sync #(
  parameter WIDTH = 5
) (
  input wire clk,
  input wire arst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= {WIDTH{1'b1}};
      dout <= {WIDTH{1'b1}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

/* File: src/step_table.v */
// Step table memory: one write port, two registered read ports.
// Assumes the writer and readers share one clock.
`timescale 1ns/10ps
module step_table #(
  parameter WIDTH = 48,
  parameter AW = 4
) (
  input wire clk,
  input wire arst_n,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr_a,
  output reg [WIDTH-1:0] rd_data_a,
  input wire [AW-1:0] rd_addr_b,
  output reg [WIDTH-1:0] rd_data_b
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Storage write
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read ports
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_a <= {WIDTH{1'b0}};
      rd_data_b <= {WIDTH{1'b0}};
    end else begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end
endmodule

/* File: src/batch_sequence_control.v */
// Batch sequencer: steps through a setpoint table, driven by discrete
// inputs and host commands, with watch channels for timers and
// concurrent outputs. Assumes weights are signed and synchronous to clk.
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`include "batch_defines.vh"
module batch_sequence_control #(
  parameter STEP_AW = 4,
  parameter NWATCH = 2,
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input wire clk,
  input wire arst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire run_gate_input_n,
  input wire start_request_input_n,
  input wire hold_input_n,
  input wire halt_input_n,
  input wire rewind_input_n,
  input wire signed [15:0] gross_weight,
  input wire signed [15:0] net_weight,
  input wire standstill,
  output reg [7:0] digital_out,
  output reg tare_request,
  output wire irq
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_FETCH = 5'h02;
  localparam [4:0] S_RUN = 5'h04;
  localparam [4:0] S_HOLD = 5'h08;
  localparam [4:0] S_STOP = 5'h10;
  localparam [STEP_AW-1:0] LAST_STEP = {STEP_AW{1'b1}};

  // True while a batch is live (fetching, running or held)
  function in_batch;
    input [4:0] st;
    begin
      in_batch = |(st & (S_FETCH | S_RUN | S_HOLD));
    end
  endfunction

  reg [4:0] state;
  reg [STEP_AW-1:0] step;
  reg [15:0] step_cnt;
  reg filling;
  reg ctrl_gate_en;
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;
  reg [STEP_AW-1:0] step_sel;
  reg [31:0] lo_shadow;
  reg ack;
  reg [3:0] prev_lvl;
  reg done_ev;
  reg gate_ev;
  reg pause_ev;
  reg [31:0] next_readdata;
  reg [7:0] watch_mask;
  reg [31:0] tick_div;
  reg tick;
  wire [4:0] din_sync;
  wire [47:0] entry;
  wire [47:0] bus_entry;
  wire [32*NWATCH-1:0] watch_cfg;
  wire [NWATCH-1:0] watch_on;
  wire [NWATCH-1:0] alarm_rise;

  // Input synchronisers
  signal_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din({rewind_input_n, halt_input_n, hold_input_n, start_request_input_n,
      run_gate_input_n}),
    .dout(din_sync)
  );

  wire gate_high = ctrl_gate_en & din_sync[0];
  wire [3:0] lvl = ~din_sync[4:1];
  wire [3:0] edge_in = lvl & ~prev_lvl;
  wire hold_lvl = lvl[1];

  // Bus handshake: every access answers on the second cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  wire wr_go = avs_write & ack;
  wire cmd_wr = wr_go & (avs_address == `REG_CMD);

  // Host start, halt and rewind commands merge with input edges; the hold command stands alone and the hold input acts as a level
  wire start_req = edge_in[0] | (cmd_wr & avs_writedata[`CMD_START]);
  wire hold_cmd = cmd_wr & avs_writedata[`CMD_HOLD];
  wire halt_req = edge_in[2] | (cmd_wr & avs_writedata[`CMD_HALT]);
  wire rewind_req = edge_in[3] | (cmd_wr & avs_writedata[`CMD_REWIND]);

  step_table #(.WIDTH(48), .AW(STEP_AW)) u_table (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(wr_go & (avs_address == `REG_STEP_HI)),
    .wr_addr(step_sel),
    .wr_data({avs_writedata[15:0], lo_shadow}),
    .rd_addr_a(step),
    .rd_data_a(entry),
    .rd_addr_b(step_sel),
    .rd_data_b(bus_entry)
  );

  // Step entry decode and weight comparison
  wire [2:0] kind = entry[`F_KIND_HI:`F_KIND_LO];
  wire [1:0] trip = entry[`F_TRIP_HI:`F_TRIP_LO];
  wire [2:0] osel = entry[`F_OSEL_HI:`F_OSEL_LO];
  wire [15:0] val = entry[`F_VAL_HI:`F_VAL_LO];
  wire [15:0] aux = entry[`F_AUX_HI:`F_AUX_LO];
  wire weigh = (kind == `KIND_GROSS) | (kind == `KIND_NET);
  wire [15:0] wsel = (kind == `KIND_NET) ? net_weight : gross_weight;
  wire signed [17:0] w = {{2{wsel[15]}}, wsel};
  wire signed [17:0] v = {2'b00, val};
  wire signed [17:0] a = {2'b00, aux};
  wire fill_now = filling | (w < v);
  wire signed [17:0] tgt = fill_now ? v + a : v;
  wire in_band = (w >= v - a) & (w <= v + a);
  wire sat = (trip == `TRIP_WITHIN_BAND_TRIP) ? in_band :
    (trip == `TRIP_LOWER) ? (w < v) : (w >= tgt);
  wire step_drive = (state == S_RUN) & weigh & ~sat & (trip != `TRIP_WITHIN_BAND_TRIP);

  // Tenth-of-second tick
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_div <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_div == TICK_CYCLES - 1);
      if (tick_div == TICK_CYCLES - 1) begin
        tick_div <= 32'h0000_0000;
      end else begin
        tick_div <= tick_div + 32'h0000_0001;
      end
    end
  end

  // Sequencer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      step <= {STEP_AW{1'b0}};
      step_cnt <= 16'h0000;
      filling <= 1'b0;
      prev_lvl <= 4'h0;
      done_ev <= 1'b0;
      gate_ev <= 1'b0;
      pause_ev <= 1'b0;
      tare_request <= 1'b0;
    end else begin
      prev_lvl <= lvl;
      done_ev <= 1'b0;
      gate_ev <= 1'b0;
      pause_ev <= 1'b0;
      tare_request <= 1'b0;
      if (rewind_req) begin
        state <= S_IDLE;
        step <= {STEP_AW{1'b0}};
      end else if (halt_req & in_batch(state)) begin
        state <= S_STOP;
      end else if (gate_high & in_batch(state)) begin
        state <= S_STOP;
        gate_ev <= 1'b1;
      end else if (start_req) begin
        if (gate_high) begin
          state <= S_IDLE;
          step <= {STEP_AW{1'b0}};
        end else if (state != S_FETCH && state != S_RUN) begin
          state <= S_FETCH;
        end
      end else if (hold_cmd & in_batch(state)) begin
        state <= S_STOP;
      end else begin
        case (state)
          S_IDLE: begin
            state <= S_IDLE;
          end
          S_STOP: begin
            state <= S_STOP;
          end
          S_HOLD: begin
            if (!hold_lvl) begin
              state <= S_FETCH;
            end
          end
          S_FETCH: begin
            step_cnt <= 16'h0000;
            filling <= 1'b0;
            state <= hold_lvl ? S_HOLD : S_RUN;
          end
          S_RUN: begin
            if (hold_lvl) begin
              state <= S_HOLD;
            end else begin
              if (tick && step_cnt != 16'hFFFF) begin
                step_cnt <= step_cnt + 16'h0001;
              end
              if (weigh) begin
                filling <= fill_now;
              end
              case (kind)
                `KIND_OFF: begin
                  state <= S_IDLE;
                  step <= {STEP_AW{1'b0}};
                  done_ev <= 1'b1;
                end
                `KIND_PAUSE: begin
                  state <= S_STOP;
                  step <= step + 1'b1;
                  pause_ev <= 1'b1;
                end
                default: begin
                  if ((weigh && sat) || (kind == `KIND_DELAY && step_cnt >= val) ||
                      (kind == `KIND_WAIT_SETTLE_KIND && standstill)) begin
                    tare_request <= (kind == `KIND_WAIT_SETTLE_KIND) & entry[`F_TARE];
                    if (step == LAST_STEP) begin
                      state <= S_IDLE;
                      step <= {STEP_AW{1'b0}};
                      done_ev <= 1'b1;
                    end else begin
                      state <= S_FETCH;
                      step <= step + 1'b1;
                    end
                  end
                end
              endcase
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Watch channels for elapsed-limit and concurrent outputs
  genvar gi;
  generate
    for (gi = 0; gi < NWATCH; gi = gi + 1) begin : g_watch
      localparam integer WAI = `REG_WATCH0 + gi;
      reg [31:0] cfg;
      reg armed;
      reg alarm;
      reg [15:0] cnt;
      wire [15:0] wval = cfg[`W_VAL_HI:`W_VAL_LO];
      wire at_start = step == cfg[`W_START_LO+STEP_AW-1:`W_START_LO];
      wire at_end = step == cfg[`W_END_LO+STEP_AW-1:`W_END_LO];
      wire concur = cfg[`W_CONCUR];
      assign watch_cfg[32*gi+31:32*gi] = cfg;
      assign watch_on[gi] = concur ?
        (armed & ((wval == 16'h0000) | (cnt < wval))) : alarm;
      // Alarm edge only where the latch below can take it, so irq matches alarm
      assign alarm_rise[gi] = ~alarm & ~concur & armed & (cnt >= wval) & cfg[`W_EN] &
        in_batch(state) & ~at_end;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cfg <= 32'h0000_0000;
          armed <= 1'b0;
          alarm <= 1'b0;
          cnt <= 16'h0000;
        end else begin
          if (wr_go && avs_address == WAI[3:0]) begin
            cfg <= avs_writedata;
          end
          if (!in_batch(state) || !cfg[`W_EN]) begin
            armed <= 1'b0;
            alarm <= 1'b0;
            cnt <= 16'h0000;
          end else if (armed && at_end) begin
            armed <= 1'b0;
            alarm <= 1'b0;
          end else if (!armed && at_start) begin
            armed <= 1'b1;
            cnt <= 16'h0000;
          end else if (armed) begin
            if (tick && cnt != 16'hFFFF) begin
              cnt <= cnt + 16'h0001;
            end
            if (alarm_rise[gi]) begin
              alarm <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // Watch outputs mapped to their output bits
  always @* begin : watch_map
    integer i;
    i = 0;
    watch_mask = 8'h00;
    for (i = 0; i < NWATCH; i = i + 1) begin
      if (watch_on[i]) begin
        watch_mask = watch_mask | (8'h01 << watch_cfg[32*i+`W_OSEL_LO +: 3]);
      end
    end
  end

  // Digital outputs: step bit while a gross or net step runs unsatisfied outside band trip, watch bits while live
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      digital_out <= 8'h00;
    end else begin
      digital_out <= (step_drive ? (8'h01 << osel) : 8'h00) |
        (in_batch(state) ? watch_mask : 8'h00);
    end
  end

  // Register read mux
  always @* begin : read_mux
    integer i;
    i = 0;
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `REG_CTRL: next_readdata[0] = ctrl_gate_en;
      `REG_STATUS: begin
        next_readdata[STEP_AW-1:0] = step;
        next_readdata[12:8] = state;
        next_readdata[16] = din_sync[0];
        next_readdata[17] = hold_lvl;
      end
      `REG_IRQ_STAT: next_readdata[3:0] = irq_stat;
      `REG_IRQ_MASK: next_readdata[3:0] = irq_mask;
      `REG_STEP_SEL: next_readdata[STEP_AW-1:0] = step_sel;
      `REG_STEP_LO: next_readdata = bus_entry[31:0];
      `REG_STEP_HI: next_readdata[15:0] = bus_entry[47:32];
      default: begin
        for (i = 0; i < NWATCH; i = i + 1) begin
          if (avs_address == `REG_WATCH0 + i) begin
            next_readdata = watch_cfg[32*i +: 32];
          end
        end
      end
    endcase
  end

  // Bus slave registers and interrupt status
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      ctrl_gate_en <= 1'b0;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      step_sel <= {STEP_AW{1'b0}};
      lo_shadow <= 32'h0000_0000;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read & ~ack) begin
        avs_readdata <= next_readdata;
      end
      if (wr_go) begin
        case (avs_address)
          `REG_CTRL: ctrl_gate_en <= avs_writedata[0];
          `REG_IRQ_MASK: irq_mask <= avs_writedata[3:0];
          `REG_STEP_SEL: step_sel <= avs_writedata[STEP_AW-1:0];
          `REG_STEP_LO: lo_shadow <= avs_writedata;
          default: lo_shadow <= lo_shadow;
        endcase
      end
      // New events win over a write-one clear
      irq_stat <= (irq_stat & ~((wr_go && avs_address == `REG_IRQ_STAT) ?
        avs_writedata[3:0] : 4'h0)) | {pause_ev, gate_ev, |alarm_rise, done_ev};
    end
  end

  assign irq = |(irq_stat & irq_mask);
endmodule

/* File: sim/batch_sequence_control_sva.sv */
// Port checker for the batch sequencer: bus handshake, gate, stop, irq.
// Assumes it is bound to batch_sequence_control, one clock domain.
`timescale 1ns/10ps
module batch_sequence_control_sva (
  input wire clk,
  input wire arst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire run_gate_input_n,
  input wire halt_input_n,
  input wire rewind_input_n,
  input wire [7:0] digital_out,
  input wire irq
);
  logic gate_en;
  logic [3:0] mask;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Shadow gate enable and interrupt mask at each accepted write
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_en <= 1'b0;
      mask <= 4'h0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == 4'h0) begin
        gate_en <= avs_writedata[0];
      end
      if (avs_address == 4'h4) begin
        mask <= avs_writedata[3:0];
      end
    end
  end
  property p_wait_first;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
  property p_wait_once;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("access longer than two");
  property p_idle_ready;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("wait without request");
  property p_cmd_zero;
    avs_read && !avs_waitrequest && avs_address == 4'h1 |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command index read not zero");
  property p_gate_hold;
    (gate_en && run_gate_input_n) [*6] |-> digital_out == 8'h00;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("outputs on with gate high");
  property p_gate_rise;
    gate_en && $rose(run_gate_input_n) |-> ##[2:6] digital_out == 8'h00;
  endproperty
  a_gate_rise: assert property (p_gate_rise) else $error("gate rise left outputs on");
  property p_halt;
    (!halt_input_n) [*6] |-> digital_out == 8'h00;
  endproperty
  a_halt: assert property (p_halt) else $error("outputs on after stop");
  property p_rewind;
    (!rewind_input_n) [*6] |-> digital_out == 8'h00;
  endproperty
  a_rewind: assert property (p_rewind) else $error("outputs on after rewind");
  property p_irq_mask;
    mask == 4'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_gate: cover property (gate_en && $rose(run_gate_input_n));
  c_irq: cover property (irq);
endmodule
bind batch_sequence_control batch_sequence_control_sva u_sva (.clk(clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .run_gate_input_n(run_gate_input_n),
  .halt_input_n(halt_input_n), .rewind_input_n(rewind_input_n),
  .digital_out(digital_out), .irq(irq));

/* File: sim/operator_switches.sv */
// Operator switch panel wired to the discrete inputs.
// Assumes each input has a pull-up; a closed switch pulls it low.
`timescale 1ns/10ps
module operator_switches (
  input wire [5:1] closed,
  output wire start_request_input_n,
  output wire run_gate_input_n,
  output wire hold_input_n,
  output wire halt_input_n,
  output wire rewind_input_n
);
  // Input 1 carries start, input 2 the run gate; open reads high
  assign start_request_input_n = !closed[1];
  assign run_gate_input_n = !closed[2];
  // Hold, stop and return-to-first-step switches
  assign hold_input_n = !closed[3];
  assign halt_input_n = !closed[4];
  assign rewind_input_n = !closed[5];
endmodule

/* File: sim/test_batch_sequence_control.sv */
// Testbench for the batch sequencer: host bus tasks and switch presses.
// Assumes the switch model and the bound port checker.
`timescale 1ns/10ps
`include "batch_defines.vh"
module test_batch_sequence_control;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [5:1] closed = 5'h00;
  logic [15:0] gross_weight = 16'h00C8;
  logic [15:0] net_weight = 16'h0000;
  logic standstill = 1'b1;
  wire run_n, start_n, hold_n, halt_n, rewind_n;
  logic [7:0] digital_out;
  logic irq;
  logic tare_request;
  logic [31:0] rd;
  logic [31:0] lo [3] = '{32'h012C_0061, 32'h0000_0003, 32'h0000_0000};
  logic [31:0] hi [3] = '{32'h0000_02BC, 32'h0000_0000, 32'h0000_0000};
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int tares = 0;
  batch_sequence_control #(.TICK_CYCLES(10)) dut (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_gate_input_n(run_n),
    .start_request_input_n(start_n), .hold_input_n(hold_n), .halt_input_n(halt_n),
    .rewind_input_n(rewind_n), .gross_weight(gross_weight), .net_weight(net_weight),
    .standstill(standstill), .digital_out(digital_out), .tare_request(tare_request),
    .irq(irq));
  operator_switches panel (.closed(closed), .start_request_input_n(start_n),
    .run_gate_input_n(run_n), .hold_input_n(hold_n), .halt_input_n(halt_n),
    .rewind_input_n(rewind_n));
  // 125 MHz clock
  initial begin
    forever begin
      #4;
      clk = ~clk;
    end
  end
  task report_and_stop;
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop;
    end
  end
  // Count tare pulses from wait-for-standstill steps
  always @(posedge clk) begin
    if (tare_request === 1'b1) begin
      tares <= tares + 1;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task bus(input logic wr_n, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= !wr_n;
    avs_read <= wr_n;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b1, a, 32'h0000_0000);
    check(rd & m, e);
  endtask
  // Load one 48-bit step entry at index s
  task put(input int s, input logic [31:0] l, input logic [31:0] h);
    wr(`REG_STEP_SEL, s);
    wr(`REG_STEP_LO, l);
    wr(`REG_STEP_HI, h);
  endtask
  task press(input int k);
    @(posedge clk);
    closed[k] <= 1'b1;
    repeat (8) @(posedge clk);
    closed[k] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task out_is(input logic [7:0] e);
    repeat (8) @(posedge clk);
    check(digital_out, e);
  endtask
  task irq_is(input logic e);
    repeat (2) @(posedge clk);
    check(irq, e);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk(`REG_CMD, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`REG_IRQ_MASK, 32'h0000_000F);
    for (int i = 0; i < 3; i++) begin
      wr(`REG_STEP_SEL, i);
      wr(`REG_STEP_LO, lo[i]);
      wr(`REG_STEP_HI, hi[i]);
    end
    wr(`REG_CMD, 32'h0000_0001);
    out_is(8'h08);
    rdchk(`REG_STATUS, 32'h0000_1F0F, 32'h0000_0400);
    closed[3] <= 1'b1;
    out_is(8'h00);
    closed[3] <= 1'b0;
    out_is(8'h08);
    wr(`REG_CMD, 32'h0000_0002);
    repeat (40) @(posedge clk);
    out_is(8'h00);
    wr(`REG_CMD, 32'h0000_0001);
    out_is(8'h08);
    press(4);
    out_is(8'h00);
    rdchk(`REG_STATUS, 32'h0000_1F0F, 32'h0000_1000);
    press(1);
    out_is(8'h08);
    wr(`REG_IRQ_STAT, 32'h0000_000F);
    gross_weight <= 16'h03E8;
    out_is(8'h00);
    rdchk(`REG_STATUS, 32'h0000_1F0F, 32'h0000_1002);
    irq_is(1'b1);
    wr(`REG_IRQ_STAT, 32'h0000_000F);
    irq_is(1'b0);
    gross_weight <= 16'h00C8;
    wr(`REG_CTRL, 32'h0000_0001);
    press(1);
    rdchk(`REG_STATUS, 32'h0000_000F, 32'h0000_0000);
    out_is(8'h00);
    closed[2] <= 1'b1;
    press(1);
    out_is(8'h08);
    wr(`REG_IRQ_STAT, 32'h0000_000F);
    closed[2] <= 1'b0;
    out_is(8'h00);
    irq_is(1'b1);
    closed[2] <= 1'b1;
    press(1);
    gross_weight <= 16'h03E8;
    out_is(8'h00);
    rdchk(`REG_STATUS, 32'h0000_000F, 32'h0000_0002);
    press(5);
    rdchk(`REG_STATUS, 32'h0000_000F, 32'h0000_0000);
    gross_weight <= 16'h00C8;
    wr(4'h8, 32'h0002_1410);
    wr(`REG_IRQ_STAT, 32'h0000_000F);
    wr(`REG_CMD, 32'h0000_0001);
    out_is(8'h08);
    repeat (40) @(posedge clk);
    check(digital_out, 8'h18);
    irq_is(1'b1);
    // In-band, wait-with-tare, net fill with a concurrent watch on bit 5
    press(5);
    wr(4'h8, 32'h0000_0000);
    wr(4'h9, 32'h0000_1D32);
    put(0, 32'h0000_0011, 32'h0000_0032);
    put(1, 32'h0000_0105, 32'h0000_0000);
    put(2, 32'h0064_0042, 32'h0000_0000);
    put(3, 32'h0000_0000, 32'h0000_0000);
    standstill <= 1'b0;
    wr(`REG_IRQ_STAT, 32'h0000_000F);
    wr(`REG_CMD, 32'h0000_0001);
    out_is(8'h00);
    rdchk(`REG_STATUS, 32'h0000_1F0F, 32'h0000_0400);
    gross_weight <= 16'h0014;
    out_is(8'h00);
    rdchk(`REG_STATUS, 32'h0000_1F0F, 32'h0000_0401);
    standstill <= 1'b1;
    out_is(8'h24);
    check(tares, 1);
    closed[3] <= 1'b1;
    out_is(8'h20);
    closed[3] <= 1'b0;
    out_is(8'h24);
    net_weight <= 16'h0064;
    out_is(8'h00);
    rdchk(`REG_STATUS, 32'h0000_1F0F, 32'h0000_0100);
    irq_is(1'b1);
    report_and_stop;
  end
endmodule
